// File: bcpd_pkg.sv
// constants for the battery check and power default block
// assumes a 200 MHz pclk and a 32-bit APB with word-aligned registers
package bcpd_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam longint CLK_HZ           = 64'd200_000_000;
  localparam longint CHECK_INTERVAL_S = 64'd86400;
  localparam longint CHECK_CYCLES     = CHECK_INTERVAL_S * CLK_HZ;

  // ***************************************************************
  // register indices, byte address is four times the index
  // ***************************************************************
  localparam int     ADDR_W        = 8;
  localparam logic [5:0] IDX_FLAGS = 6'h00;
  localparam logic [5:0] IDX_ALARM = 6'h06;
  localparam logic [5:0] IDX_WDOG  = 6'h07;
  localparam logic [5:0] IDX_TCTL  = 6'h0c;
  localparam logic [5:0] IDX_HOLD  = 6'h10;
  localparam logic [5:0] IDX_ISTS  = 6'h11;
  localparam logic [5:0] IDX_IMASK = 6'h12;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int FLAGS_BL_BIT      = 4;
  localparam int FLAGS_DEFINED_BIT = 0;
  localparam int ALARM_AFE_BIT     = 7;
  localparam int ALARM_ABE_BIT     = 5;
  localparam int WDOG_STEER_BIT    = 7;
  localparam int TCTL_FT_BIT       = 6;
  localparam int HOLD_WR_BIT       = 1;
  localparam int HOLD_RD_BIT       = 0;

  localparam logic [7:0] ALARM_EN_MASK = 8'ha0;
  localparam logic [7:0] TCTL_FT_MASK  = 8'h40;

  // interrupt status bits
  localparam int EV_LOW_BIT  = 0;
  localparam int EV_PASS_BIT = 1;
  localparam int EV_UP_BIT   = 2;
  localparam int EV_DOWN_BIT = 3;
  localparam int EV_W        = 4;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0]      RST_BYTE  = 8'h00;
  localparam logic [1:0]      RST_HOLD  = 2'h0;
  localparam logic [EV_W-1:0] RST_EV    = 4'h0;
  localparam logic [31:0]     RST_WORD  = 32'h0000_0000;
  localparam logic [63:0]     RST_COUNT = 64'h0000_0000_0000_0000;

endpackage

// File: bcpd_tmr_if.sv
// link between the sequencer and its check interval timer
// assumes both ends share pclk
`timescale 1ns/100ps
interface bcpd_tmr_if;
  logic run;
  logic restart;
  logic tick;

  modport ctl (output run, output restart, input tick);
  modport tmr (input run, input restart, output tick);
endinterface

// File: bcpd_interval_timer.sv
// interval timer that pulses once per battery check period
// assumes run and restart come from flip-flops in the same domain
`timescale 1ns/100ps
module bcpd_interval_timer
  import bcpd_pkg::*;
#(
  parameter longint INTERVAL = CHECK_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  bcpd_tmr_if.tmr   tmr
);

  typedef struct packed {
    logic [63:0] count;
    logic        tick;
  } bcpd_tmr_state_t;

  bcpd_tmr_state_t state_reg;
  bcpd_tmr_state_t state_next;

  // ***************************************************************
  // counting
  // ***************************************************************
  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    // count is held at zero while running on battery, no checks then
    if (!tmr.run || tmr.restart) begin
      state_next.count = RST_COUNT;
    end else if (state_reg.count == 64'(INTERVAL - 64'd1)) begin
      state_next.count = RST_COUNT;
      state_next.tick  = 1'b1;
    end else begin
      state_next.count = state_reg.count + 64'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign tmr.tick = state_reg.tick;

endmodule

// File: bcpd_top.sv
// battery check monitor and power-state defaults of the control bits
// assumes synchronous supply, attach and comparator inputs and an APB master
//
// Behaviour
// - check battery at each power-up and once a day while supplied.
// - battery below threshold sets the low flag, bit 4 of flags register.
// - low flag stays set until a later check passes.
// - no checks while running on battery back-up.
// - power applied clears steer, multiplier, resolution, alarm enables, write hold, test.
// - reset clears holds, test, alarm enables and watchdog register only.
// - power-down clears write hold, test, watchdog; keeps read hold, alarm enables.
// - after first power-up, other control bits are undefined until written.
// - test bit 6 of Ch, alarm enable bit 7 of 6h, steer bit 7 of 7h.
`timescale 1ns/100ps
module bcpd_top
  import bcpd_pkg::*;
#(
  parameter longint CHECK_INTERVAL = CHECK_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              vcc_good,
  input  wire logic              battery_attach,
  input  wire logic              reset_req,
  input  wire logic              battery_ok,
  output logic                   battery_low_flag,
  output logic                   irq
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic            vcc_prev;
    logic            bl;
    logic            defined;
    logic [7:0]      alarm;
    logic [7:0]      wdog;
    logic [7:0]      tctl;
    logic [1:0]      hold;
    logic [EV_W-1:0] ists;
    logic [EV_W-1:0] imask;
    logic            restart;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            irq;
  } bcpd_state_t;

  bcpd_state_t state_reg;
  bcpd_state_t state_next;

  bcpd_tmr_if tmr_link ();

  bcpd_interval_timer #(
    .INTERVAL (CHECK_INTERVAL)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tmr     (tmr_link.tmr)
  );

  // timer only runs while the supply is nominal
  assign tmr_link.run     = state_reg.vcc_prev;
  assign tmr_link.restart = state_reg.restart;

  // ***************************************************************
  // next state
  // ***************************************************************
  logic            power_up;
  logic            power_down;
  logic            check_now;
  logic            access;
  logic [5:0]      index;
  logic            aligned;
  logic            do_write;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] read_clear;

  always_comb begin
    state_next         = state_reg;
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.restart = 1'b0;
    events             = RST_EV;
    read_clear         = RST_EV;
    power_up           = vcc_good & ~state_reg.vcc_prev;
    power_down         = ~vcc_good & state_reg.vcc_prev;
    state_next.vcc_prev = vcc_good;
    access             = psel & penable & ~state_reg.pready;
    index              = paddr[ADDR_W-1:2];
    aligned            = (paddr[1:0] == 2'h0);
    // writes are ignored on battery, the bus still answers them with pready
    do_write           = access & pwrite & vcc_good;

    // ---------------- bus access, one wait state ----------------
    if (access) begin
      state_next.pready = 1'b1;
      state_next.prdata = RST_WORD;
      if (!aligned) begin
        state_next.pslverr = 1'b1;
      end else begin
        case (index)
          IDX_FLAGS: begin
            state_next.prdata[FLAGS_BL_BIT]      = state_reg.bl;
            state_next.prdata[FLAGS_DEFINED_BIT] = state_reg.defined;
          end
          IDX_ALARM: begin
            state_next.prdata[7:0] = state_reg.alarm;
            if (do_write) begin
              state_next.alarm   = pwdata[7:0];
              state_next.defined = 1'b1;
            end
          end
          IDX_WDOG: begin
            state_next.prdata[7:0] = state_reg.wdog;
            if (do_write) begin
              state_next.wdog = pwdata[7:0];
            end
          end
          IDX_TCTL: begin
            state_next.prdata[7:0] = state_reg.tctl;
            if (do_write) begin
              state_next.tctl    = pwdata[7:0];
              state_next.defined = 1'b1;
            end
          end
          IDX_HOLD: begin
            state_next.prdata[1:0] = state_reg.hold;
            if (do_write) begin
              state_next.hold = pwdata[1:0];
            end
          end
          IDX_ISTS: begin
            state_next.prdata[EV_W-1:0] = state_reg.ists;
            if (!pwrite) begin
              read_clear = state_reg.ists;
            end
          end
          IDX_IMASK: begin
            state_next.prdata[EV_W-1:0] = state_reg.imask;
            if (do_write) begin
              state_next.imask = pwdata[EV_W-1:0];
            end
          end
          default: begin
            state_next.pslverr = 1'b1;
          end
        endcase
      end
    end

    // ---------------- battery checks ----------------
    // a power-up check and the daily tick share one path
    check_now = (power_up | battery_attach | tmr_link.tick) & vcc_good;
    if (check_now) begin
      // flag follows each check result, so only a passing check clears it
      state_next.bl = ~battery_ok;
      events[EV_LOW_BIT]  = ~battery_ok;
      events[EV_PASS_BIT] = battery_ok & state_reg.bl;
    end
    if (power_up) begin
      state_next.restart = 1'b1;
    end
    events[EV_UP_BIT]   = power_up | battery_attach;
    events[EV_DOWN_BIT] = power_down;

    // ---------------- power-state defaults ----------------
    // these win over a same-cycle write so the defaults always land
    if (power_down) begin
      // read hold and alarm enables ride through back-up
      state_next.hold[HOLD_WR_BIT] = 1'b0;
      state_next.tctl              = state_reg.tctl & ~TCTL_FT_MASK;
      state_next.wdog              = RST_BYTE;
    end
    if (power_up || battery_attach) begin
      // steer, multiplier and resolution all live in the watchdog byte
      state_next.wdog              = RST_BYTE;
      state_next.alarm             = state_reg.alarm & ~ALARM_EN_MASK;
      state_next.tctl              = state_reg.tctl & ~TCTL_FT_MASK;
      state_next.hold[HOLD_WR_BIT] = 1'b0;
    end
    if (battery_attach) begin
      // nothing else is known to be sane after a fresh battery
      state_next.hold[HOLD_RD_BIT] = 1'b0;
      state_next.defined           = 1'b0;
    end
    if (reset_req) begin
      // other control bits are left alone
      state_next.hold  = RST_HOLD;
      state_next.tctl  = state_reg.tctl & ~TCTL_FT_MASK;
      state_next.alarm = state_reg.alarm & ~ALARM_EN_MASK;
      state_next.wdog  = RST_BYTE;
    end

    // ---------------- interrupt ----------------
    // a new event beats the read that clears it
    state_next.ists = (state_reg.ists & ~read_clear) | events;
    state_next.irq  = |(state_next.ists & state_next.imask);
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign prdata           = state_reg.prdata;
  assign pready           = state_reg.pready;
  assign pslverr          = state_reg.pslverr;
  assign battery_low_flag = state_reg.bl;
  assign irq              = state_reg.irq;

endmodule

// File: bcpd_props.sv
// checker for the battery check block, sees the top ports only
// assumes one pclk domain and a check interval under 990 cycles in sim
`timescale 1ns/100ps
module bcpd_props
  import bcpd_pkg::*;
#(
  parameter longint CHECK_INTERVAL = CHECK_CYCLES
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              vcc_good,
  input wire logic              battery_attach,
  input wire logic              reset_req,
  input wire logic              battery_ok,
  input wire logic              battery_low_flag,
  input wire logic              irq
);
  // ******************************************
  // properties
  // ******************************************
  // a real day of cycles cannot be bounded, so the daily check is only judged when short
  localparam int LIM = 998;
  localparam bit SHORT = CHECK_INTERVAL < 990;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);
  property p_up_low; $rose(vcc_good) && !battery_ok |=> battery_low_flag; endproperty
  a_up_low: assert property (p_up_low) else $error("low battery not flagged at power-up");
  property p_up_ok; $rose(vcc_good) && battery_ok |=> !battery_low_flag; endproperty
  a_up_ok: assert property (p_up_ok) else $error("flag not cleared by passing check");
  property p_rise; $rose(battery_low_flag) |-> $past(vcc_good) && !$past(battery_ok); endproperty
  a_rise: assert property (p_rise) else $error("flag set without a failing check");
  property p_fall; $fell(battery_low_flag) |-> $past(vcc_good) && $past(battery_ok); endproperty
  a_fall: assert property (p_fall) else $error("flag cleared without a passing check");
  property p_backup; !vcc_good |=> $stable(battery_low_flag); endproperty
  a_backup: assert property (p_backup) else $error("flag moved on backup power");
  property p_daily;
    SHORT && vcc_good && $past(vcc_good) && $fell(battery_ok)
      |-> ##[1:LIM] (battery_low_flag || !vcc_good || battery_ok);
  endproperty
  a_daily: assert property (p_daily) else $error("periodic check missing");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_setup; psel && !penable |=> !pready; endproperty
  a_setup: assert property (p_setup) else $error("apb answer in setup");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error without ready or with data");
  property p_map; psel && penable && !pready && paddr[7:2] == 6'h3f |=> pslverr; endproperty
  a_map: assert property (p_map) else $error("unmapped access not refused");
endmodule

bind bcpd_top bcpd_props #(.CHECK_INTERVAL(CHECK_INTERVAL)) u_bcpd_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .vcc_good(vcc_good), .battery_attach(battery_attach),
  .reset_req(reset_req), .battery_ok(battery_ok), .battery_low_flag(battery_low_flag), .irq(irq));

// File: bcpd_top_test.sv
// self-checking bench for the battery check block over apb
// assumes a 5 ns pclk and the check interval shortened to 50 cycles
`timescale 1ns/100ps
module bcpd_top_test;
  import bcpd_pkg::*;
  logic              pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, err, irq, battery_low_flag;
  logic              vcc_good = 0, battery_attach = 0, reset_req = 0, battery_ok = 1;
  logic [5:0]        ix [5] = '{IDX_ALARM, IDX_WDOG, IDX_TCTL, IDX_HOLD, IDX_IMASK};
  int                n_fail = 0, checks = 0;

  initial forever #2.5 pclk = ~pclk;

  bcpd_top #(.CHECK_INTERVAL(50)) u_bcpd_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vcc_good(vcc_good), .battery_attach(battery_attach),
    .reset_req(reset_req), .battery_ok(battery_ok), .battery_low_flag(battery_low_flag), .irq(irq));

  // ******************************************
  // tasks
  // ******************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  // waits a clock first so a release and the next setup never share a time step
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    xfer(0, idx, 32'h0000_0000);
    chk($sformatf("reg %h", idx), exp, rd);
  endtask
  task automatic all(input logic [31:0] e [5]);
    foreach (ix[i]) rdc(ix[i], e[i]);
  endtask
  task automatic fill;
    foreach (ix[i]) xfer(1, ix[i], 32'hffff_ffff);
  endtask
  task automatic pw(input logic v, input logic ok);
    @(posedge pclk);
    vcc_good <= v;
    battery_ok <= ok;
    repeat (3) @(posedge pclk);
  endtask
  task automatic summarize;
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ******************************************
  // tests
  // ******************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    all('{0, 0, 0, 0, 0});
    pw(1, 0);
    chk("flag", 1, battery_low_flag);
    battery_ok <= 1'b1;
    rdc(IDX_FLAGS, 32'h0000_0010);
    chk("flag held", 1, battery_low_flag);
    chk("irq", 0, irq);
    xfer(1, IDX_IMASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    rdc(IDX_ISTS, 32'h0000_0005);
    repeat (2) @(posedge pclk);
    chk("irq", 0, irq);
    repeat (60) @(posedge pclk);
    chk("flag", 0, battery_low_flag);
    rdc(IDX_ISTS, 32'h0000_0002);
    battery_ok <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("flag", 1, battery_low_flag);
    chk("irq", 1, irq);
    rdc(IDX_ISTS, 32'h0000_0001);
    pw(0, 1);
    repeat (120) @(posedge pclk);
    chk("flag", 1, battery_low_flag);
    rdc(IDX_ISTS, 32'h0000_0008);
    pw(1, 1);
    chk("flag", 0, battery_low_flag);
    rdc(IDX_ISTS, 32'h0000_0006);
    fill();
    all('{32'hff, 32'hff, 32'hff, 32'h3, 32'hf});
    rdc(IDX_FLAGS, 32'h0000_0001);
    @(posedge pclk);
    reset_req <= 1'b1;
    @(posedge pclk);
    reset_req <= 1'b0;
    all('{32'h5f, 32'h0, 32'hbf, 32'h0, 32'hf});
    fill();
    pw(0, 1);
    all('{32'hff, 32'h0, 32'hbf, 32'h1, 32'hf});
    // a write on battery is answered but dropped, the mask must stay all ones
    xfer(1, IDX_IMASK, 32'h0000_0000);
    pw(1, 1);
    all('{32'h5f, 32'h0, 32'hbf, 32'h1, 32'hf});
    @(posedge pclk);
    battery_attach <= 1'b1;
    @(posedge pclk);
    battery_attach <= 1'b0;
    rdc(IDX_HOLD, 32'h0000_0000);
    rdc(IDX_FLAGS, 32'h0000_0000);
    xfer(0, 6'h3f, 32'h0000_0000);
    chk("slverr", 1, err);
    chk("unmapped data", 0, rd);
    xfer(1, IDX_FLAGS, 32'hffff_ffff);
    rdc(IDX_FLAGS, 32'h0000_0000);
    // a failing attach check while the enable is low must not be seen at all
    clk_en <= 1'b0;
    battery_ok <= 1'b0;
    battery_attach <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("frozen flag", 0, battery_low_flag);
    clk_en <= 1'b1;
    battery_ok <= 1'b1;
    battery_attach <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("thawed flag", 0, battery_low_flag);
    summarize();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule
